// >>> verilog/profile2_synth_config_regs.sv
// profile-2 synthesizer configuration bank behind an apb slave
//
// Contract
// [R01] fsk and oscillator select register at index 0x18, reset 0x0010
// [R02] output buffer control register at index 0x17, reset 0x10a4
// [R03] divider, filter and scaler register at index 0x16, reset 0x8584
// [R04] software writes zeros to the unused fields of both registers
// [R05] bit 10 enables fsk; software keeps fractional denominator zero meanwhile
// [R06] bits 9..6 external-oscillator channel divider code; 1 and 11..15 reserved
// [R07] bit 5 selects internal (0) or external (1) oscillator operation
// [R08] bits 4..0 transmit output power, reset 0x10
// [R09] bits 12..8 receive output power, reset 0x10
// [R10] bit 7 enables transmit output port, reset 1
// [R11] bit 6 enables receive output port, reset 0
// [R12] bits 2..0 fourth pole resistor, 0 bypass, reset 4
// [R13] bits 15..13 third pole resistor, 0 bypass, reset 4
// [R14] bits 12..10 second channel divider, codes 0..6, reset 1
// [R15] bits 9..8 first channel divider, divide by 4..7, reset 1
// [R16] software keeps phase detector delay within recommended limits
// [R17] bits 4..0 reference scaler factor; 0 and 14..31 reserved
// [R18] software programs scaler factor above the reference pre-divider
// [R19] software leaves the scaler in bypass with a crystal reference
// [R20] every field reads back exactly the last written value
`timescale 1ns/10ps
module profile2_synth_config_regs
  import profile2_regs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output profile2_cfg_t    cfg,
  output profile2_flags_t  reserved_code
);

  logic [REG_W-1:0] div_filt;
  logic [REG_W-1:0] outbuf;
  logic [REG_W-1:0] fsk_osc;

  // byte address is four times the printed index
  wire [APB_AW-1:0] word_idx   = paddr[APB_AW+1:2];
  wire              setup      = psel && !penable;
  wire              hit_div    = (word_idx == IDX_DIV_FILT);
  wire              hit_outbuf = (word_idx == IDX_OUTBUF);
  wire              hit_fsk    = (word_idx == IDX_FSK_OSC);
  wire              hit_any    = hit_div || hit_outbuf || hit_fsk;
  wire              access     = psel && penable && pready;
  wire              wr_ok      = access && pwrite && hit_any && !pslverr;

  // only the low two byte lanes carry data; a partial write merges lane by lane
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                             input logic [31:0]      new_v,
                                             input logic [3:0]       strb);
    logic [REG_W-1:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  wire [REG_W-1:0] wdata_div    = merge(div_filt, pwdata, pstrb);
  wire [REG_W-1:0] wdata_outbuf = merge(outbuf, pwdata, pstrb);
  wire [REG_W-1:0] wdata_fsk    = merge(fsk_osc, pwdata, pstrb);

  cfg_word_reg #(.RESET_VALUE(RST_DIV_FILT)) u_div_filt ( // [R03]
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ok && hit_div),
    .wr_data (wdata_div),
    .value   (div_filt)
  );

  cfg_word_reg #(.RESET_VALUE(RST_OUTBUF)) u_outbuf ( // [R02]
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ok && hit_outbuf),
    .wr_data (wdata_outbuf),
    .value   (outbuf)
  );

  cfg_word_reg #(.RESET_VALUE(RST_FSK_OSC)) u_fsk_osc ( // [R01]
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ok && hit_fsk),
    .wr_data (wdata_fsk),
    .value   (fsk_osc)
  );

  // unused fields are stored as written; the block does not mask them off [R04] [R20]
  wire [REG_W-1:0] rd_word = hit_div    ? div_filt :
                             hit_outbuf ? outbuf   :
                             hit_fsk    ? fsk_osc  : '0;

  // field decode into the configuration carrier
  profile2_cfg_t next_cfg;
  assign next_cfg.fsk_enable               = fsk_osc[FSK_EN_BIT];            // [R05]
  assign next_cfg.ext_osc_channel_divider  = fsk_osc[EXT_DIV_HI:EXT_DIV_LO]; // [R06]
  assign next_cfg.oscillator_source_select = fsk_osc[OSC_SEL_BIT];           // [R07]
  assign next_cfg.tx_output_power          = fsk_osc[TX_PWR_HI:TX_PWR_LO];   // [R08]
  assign next_cfg.rx_output_power          = outbuf[RX_PWR_HI:RX_PWR_LO];    // [R09]
  assign next_cfg.tx_output_enable         = outbuf[TX_EN_BIT];              // [R10]
  assign next_cfg.rx_output_enable         = outbuf[RX_EN_BIT];              // [R11]
  assign next_cfg.fourth_pole_resistor     = outbuf[R4_HI:R4_LO];            // [R12]
  assign next_cfg.third_pole_resistor      = div_filt[R3_HI:R3_LO];          // [R13]
  assign next_cfg.second_channel_divider   = div_filt[DIV2_HI:DIV2_LO];      // [R14]
  assign next_cfg.first_channel_divider    = div_filt[DIV1_HI:DIV1_LO];      // [R15]
  assign next_cfg.phase_detector_delay     = div_filt[PFD_HI:PFD_LO];
  assign next_cfg.reference_scaler_factor  = div_filt[MULT_HI:MULT_LO];      // [R17]

  // reserved codes are flagged, not blocked: software owns the choice of code
  profile2_flags_t next_flags;
  assign next_flags.ext_div_reserved =
    (next_cfg.ext_osc_channel_divider == EXT_DIV_RSVD_ONE) ||
    (next_cfg.ext_osc_channel_divider > EXT_DIV_MAX);                      // [R06]
  assign next_flags.div2_reserved    = (next_cfg.second_channel_divider > DIV2_MAX); // [R14]
  assign next_flags.mult_reserved    =
    (next_cfg.reference_scaler_factor < MULT_MIN) ||
    (next_cfg.reference_scaler_factor > MULT_MAX);                         // [R17]

  // answer takes one wait cycle: pready rises in the second access cycle
  wire next_pready = psel && penable && !pready;
  wire next_err    = setup && !hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready <= next_pready;
      if (setup) begin
        pslverr <= next_err;
        prdata  <= (!pwrite && hit_any) ? {16'h0000, rd_word} : '0;
      end else if (access) begin
        pslverr <= 1'b0;
        prdata  <= '0;
      end
    end
  end

  // outputs registered; they follow the register by one cycle, a write by two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg           <= {RST_FSK_OSC[FSK_EN_BIT], RST_FSK_OSC[EXT_DIV_HI:EXT_DIV_LO],
                        RST_FSK_OSC[OSC_SEL_BIT], RST_FSK_OSC[TX_PWR_HI:TX_PWR_LO],
                        RST_OUTBUF[RX_PWR_HI:RX_PWR_LO], RST_OUTBUF[TX_EN_BIT],
                        RST_OUTBUF[RX_EN_BIT], RST_OUTBUF[R4_HI:R4_LO],
                        RST_DIV_FILT[R3_HI:R3_LO], RST_DIV_FILT[DIV2_HI:DIV2_LO],
                        RST_DIV_FILT[DIV1_HI:DIV1_LO], RST_DIV_FILT[PFD_HI:PFD_LO],
                        RST_DIV_FILT[MULT_HI:MULT_LO]};
      reserved_code <= '0;
    end else begin
      cfg           <= next_cfg;
      reserved_code <= next_flags;
    end
  end

  // assertions
  sequence s_write_fsk;
    psel && penable && pready && pwrite && hit_fsk && (pstrb == 4'hf);
  endsequence

  sequence s_write_outbuf;
    psel && penable && pready && pwrite && hit_outbuf && (pstrb == 4'hf);
  endsequence

  property p_readback_fsk;
    @(posedge pclk) disable iff (!presetn)
      s_write_fsk |=> (fsk_osc == $past(pwdata[15:0]));
  endproperty

  a_fsk_word_store: assert property (p_readback_fsk) // [R20]
    else $error("fsk/osc word did not store the write");

  a_outbuf_word_store: assert property ( // [R02]
    @(posedge pclk) disable iff (!presetn)
      s_write_outbuf |=> (outbuf == $past(pwdata[15:0])))
    else $error("output buffer word did not store the write");

  a_div_hold_other: assert property ( // [R03]
    @(posedge pclk) disable iff (!presetn)
      !(wr_ok && hit_div) |=> $stable(div_filt))
    else $error("divider word changed without a write to it");

  a_tx_enable_follow: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
      s_write_outbuf |=> ##1 (cfg.tx_output_enable == $past(pwdata[TX_EN_BIT], 2)))
    else $error("transmit enable output does not follow its bit");

  a_rx_enable_follow: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
      ##1 (cfg.rx_output_enable == $past(outbuf[RX_EN_BIT])))
    else $error("receive enable output does not follow its bit");

  a_osc_sel_follow: assert property ( // [R07]
    @(posedge pclk) disable iff (!presetn)
      s_write_fsk |=> ##1 (cfg.oscillator_source_select == $past(pwdata[OSC_SEL_BIT], 2)))
    else $error("oscillator select output does not follow its bit");

  a_fsk_en_follow: assert property ( // [R05]
    @(posedge pclk) disable iff (!presetn)
      ##1 (cfg.fsk_enable == $past(fsk_osc[FSK_EN_BIT])))
    else $error("fsk enable output does not follow its bit");

  a_mult_reserved_flag: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
      ##1 (reserved_code.mult_reserved ==
           (($past(div_filt[MULT_HI:MULT_LO]) == 5'h00) || ($past(div_filt[MULT_HI:MULT_LO]) > MULT_MAX))))
    else $error("scaler reserved flag wrong");

  a_apb_one_wait: assert property ( // apb one-wait answer; no contract rule covers it
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not given in second access cycle");

endmodule

// >>> verilog/profile2_regs_pkg.sv
// package: register map, field layout and reset values of the profile-2 configuration bank
package profile2_regs_pkg;

  localparam int unsigned REG_W      = 16;
  localparam int unsigned APB_AW     = 8;

  // printed offsets are not all multiples of four: these are word indices
  localparam logic [APB_AW-1:0] IDX_DIV_FILT   = 8'h16;
  localparam logic [APB_AW-1:0] IDX_OUTBUF     = 8'h17;
  localparam logic [APB_AW-1:0] IDX_FSK_OSC    = 8'h18;

  localparam logic [REG_W-1:0] RST_DIV_FILT    = 16'h8584;
  localparam logic [REG_W-1:0] RST_OUTBUF      = 16'h10a4;
  localparam logic [REG_W-1:0] RST_FSK_OSC     = 16'h0010;

  // fsk / oscillator select register fields
  localparam int unsigned FSK_EN_BIT       = 10;
  localparam int unsigned EXT_DIV_HI       = 9;
  localparam int unsigned EXT_DIV_LO       = 6;
  localparam int unsigned OSC_SEL_BIT      = 5;
  localparam int unsigned TX_PWR_HI        = 4;
  localparam int unsigned TX_PWR_LO        = 0;

  // output buffer control register fields
  localparam int unsigned RX_PWR_HI        = 12;
  localparam int unsigned RX_PWR_LO        = 8;
  localparam int unsigned TX_EN_BIT        = 7;
  localparam int unsigned RX_EN_BIT        = 6;
  localparam int unsigned R4_HI            = 2;
  localparam int unsigned R4_LO            = 0;

  // divider / filter / scaler register fields
  localparam int unsigned R3_HI            = 15;
  localparam int unsigned R3_LO            = 13;
  localparam int unsigned DIV2_HI          = 12;
  localparam int unsigned DIV2_LO          = 10;
  localparam int unsigned DIV1_HI          = 9;
  localparam int unsigned DIV1_LO          = 8;
  localparam int unsigned PFD_HI           = 7;
  localparam int unsigned PFD_LO           = 5;
  localparam int unsigned MULT_HI          = 4;
  localparam int unsigned MULT_LO          = 0;

  // code limits
  localparam logic [3:0] EXT_DIV_RSVD_ONE  = 4'h1;
  localparam logic [3:0] EXT_DIV_MAX       = 4'ha;
  localparam logic [2:0] DIV2_MAX          = 3'h6;
  localparam logic [4:0] MULT_MIN          = 5'h01;
  localparam logic [4:0] MULT_MAX          = 5'h0d;

  typedef struct packed {
    logic       fsk_enable;
    logic [3:0] ext_osc_channel_divider;
    logic       oscillator_source_select;
    logic [4:0] tx_output_power;
    logic [4:0] rx_output_power;
    logic       tx_output_enable;
    logic       rx_output_enable;
    logic [2:0] fourth_pole_resistor;
    logic [2:0] third_pole_resistor;
    logic [2:0] second_channel_divider;
    logic [1:0] first_channel_divider;
    logic [2:0] phase_detector_delay;
    logic [4:0] reference_scaler_factor;
  } profile2_cfg_t;

  typedef struct packed {
    logic ext_div_reserved;
    logic div2_reserved;
    logic mult_reserved;
  } profile2_flags_t;

endpackage

// >>> verilog/cfg_word_reg.sv
// one 16-bit read/write configuration word with its own reset value
`timescale 1ns/10ps
module cfg_word_reg
  import profile2_regs_pkg::*;
#(
  parameter logic [REG_W-1:0] RESET_VALUE = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [REG_W-1:0] wr_data,
  output logic      [REG_W-1:0] value
);

  // every bit is stored, unused ones too, so readback matches the last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule

// >>> verification/profile2_synth_config_regs_tb_top.sv
// self-checking bench: apb traffic against a behavioural register model
`timescale 1ns/10ps
module profile2_synth_config_regs_tb_top;
  import profile2_regs_pkg::*;
  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [9:0]      paddr;
  logic [31:0]     pwdata;
  logic [3:0]      pstrb;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  profile2_cfg_t   cfg;
  profile2_flags_t reserved_code;
  int              err_count;
  int              checked;
  logic [15:0]     mdl [3];
  logic [31:0]     seed;
  logic [31:0]     rd;
  logic            er;
  logic [23:0]     dir [7] = '{24'h180040, 24'h180280, 24'h1802c0, 24'h181fff,
                               24'h161c0d, 24'h160000, 24'h16000e};

  profile2_synth_config_regs profile2_synth_config_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .reserved_code(reserved_code));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // software side of the bank: unused fields zero, delay 3 or 4 suits every mode,
  // scaler kept above a pre-divider of 1; the reference is an oscillator, not a crystal
  function automatic logic [31:0] legal(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    q = d;
    if (idx == 8'h18) q[15:11] = 5'h00;
    if (idx == 8'h17) begin
      q[15:13] = 3'h0;
      q[5:3]   = 3'h0;
    end
    if (idx == 8'h16) begin
      q[7:5] = q[5] ? 3'h4 : 3'h3;
      if (q[4:1] == 4'h0) q[1] = 1'b1;
    end
    return q;
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // model reset uses its own literals, not the package constants
  task automatic mdl_reset();
    mdl = '{16'h8584, 16'h10a4, 16'h0010};
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic access(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    int               k;
    logic             hit;
    logic [15:0]      f;
    logic [15:0]      o;
    logic [15:0]      v;
    profile2_cfg_t    c;
    profile2_flags_t  fl;
    k   = int'(idx) - 22;
    hit = (k >= 0 && k < 3);
    if (w) d = legal(idx, d);
    apb(w, idx, d, s);
    chk("pslverr", {63'h0, ~hit}, {63'h0, er});
    if (w && hit) begin
      if (s[0]) mdl[k][7:0] = d[7:0];
      if (s[1]) mdl[k][15:8] = d[15:8];
    end
    if (!w) chk("prdata", hit ? {48'h0, mdl[k]} : 64'h0, {32'h0, rd});
    // decoded outputs lag the register by one cycle
    repeat (2) @(posedge pclk);
    f = mdl[2];
    o = mdl[1];
    v = mdl[0];
    c = '{f[10], f[9:6], f[5], f[4:0], o[12:8], o[7], o[6], o[2:0],
          v[15:13], v[12:10], v[9:8], v[7:5], v[4:0]};
    fl = '{(f[9:6] == 4'h1) || (f[9:6] > 4'ha), v[12:10] > 3'h6, (v[4:0] == 5'h0) || (v[4:0] > 5'hd)};
    chk("cfg", {27'h0, c}, {27'h0, cfg});
    chk("reserved_code", {61'h0, fl}, {61'h0, reserved_code});
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    mdl_reset();
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    conclude();
  end

  initial begin
    int          i;
    logic [31:0] r;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    err_count = 0;
    checked = 0;
    seed = 32'd19063;
    mdl_reset();
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    access(1'b0, 8'h18, 32'h0, 4'h0);
    access(1'b0, 8'h17, 32'h0, 4'h0);
    access(1'b0, 8'h16, 32'h0, 4'h0);
    // boundary codes of the external-oscillator divider, second divider and scaler fields, upper data lanes set
    for (i = 0; i < 7; i++) begin
      access(1'b1, dir[i][23:16], {16'hffff, dir[i][15:0]}, 4'hf);
      access(1'b0, dir[i][23:16], 32'h0, 4'h0);
    end
    for (i = 0; i < 80; i++) begin
      r = rnd();
      access(r[11], (r[9:8] == 2'h3) ? (r[10] ? 8'h15 : 8'h19) : 8'h16 + {6'h0, r[9:8]},
             rnd(), r[15:12]);
    end
    do_reset();
    for (i = 0; i < 3; i++) access(1'b0, 8'h16 + i[7:0], 32'h0, 4'h0);
    conclude();
  end
endmodule
